// *** inc/arc_pkg.sv ***
// Constants and types of the reference timing and pair configuration block
`default_nettype none
package arc_pkg;
	// Setup byte layout
	localparam logic [1:0] ARC_SETUP_ID     = 2'b01;
	localparam int         ARC_ID_HI_BIT    = 7;
	localparam int         ARC_ID_LO_BIT    = 6;
	localparam int         ARC_CLK_HI_BIT   = 5;
	localparam int         ARC_CLK_LO_BIT   = 4;
	localparam int         ARC_REF_HI_BIT   = 3;
	localparam int         ARC_REF_LO_BIT   = 2;
	localparam int         ARC_PAIR_HI_BIT  = 1;
	localparam int         ARC_PAIR_LO_BIT  = 0;
	// Pair register layout: bits 7..4 hold pairs 01, 23, 45, 67
	localparam int         ARC_PAIR_MSB     = 7;
	localparam int         ARC_PAIR_LSB     = 4;
	// Values after reset
	localparam logic [1:0] ARC_CLK_MODE_RST = 2'b10;
	localparam logic [1:0] ARC_REF_MODE_RST = 2'b10;
	localparam logic [1:0] ARC_PAIR_SEL_RST = 2'b00;
	localparam logic [3:0] ARC_PAIR_RST     = 4'h0;
	// Mode codes
	localparam logic [1:0] ARC_CLK_EXT      = 2'b11;
	// Reference delays in conversion clock cycles
	localparam int         ARC_CNT_W        = 8;
	localparam logic [7:0] ARC_WAKE_CYC     = 8'd218;
	localparam logic [7:0] ARC_SETTLE_CYC   = 8'd244;
	localparam logic [7:0] ARC_TEMP_LAT_CYC = 8'd188;

	typedef enum logic {
		ARC_ST_CMD  = 1'b0,
		ARC_ST_DATA = 1'b1
	} arc_cmd_st_t;

	typedef enum logic [1:0] {
		ARC_R_IDLE   = 2'b00,
		ARC_R_WAKE   = 2'b01,
		ARC_R_SETTLE = 2'b10,
		ARC_R_TOUT   = 2'b11
	} arc_ref_st_t;
endpackage
`default_nettype wire

// *** inc/arc_ser_if.sv ***
// Serial receiver to core connection
`timescale 1ns/1ps
`default_nettype none
interface arc_ser_if;
	logic       sclk_rise;
	logic       frame_act;
	logic       byte_stb;
	logic [7:0] byte_data;
	modport rx (output sclk_rise, output frame_act, output byte_stb, output byte_data);
	modport core (input sclk_rise, input frame_act, input byte_stb, input byte_data);
endinterface
`default_nettype wire

// *** rtl/arc_ser_rx.sv ***
// Serial pin synchroniser and byte assembler
`timescale 1ns/1ps
`default_nettype none
module arc_ser_rx
	import arc_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic cs_n,
	input  wire logic sclk,
	input  wire logic sdi,
	arc_ser_if.rx     ser
);
	logic [1:0] cs_sync_q;
	logic [1:0] sclk_sync_q;
	logic [1:0] sdi_sync_q;
	logic       sclk_prev_q;
	logic [2:0] bit_cnt_q, bit_cnt_d;
	logic [7:0] shift_q, shift_d;
	logic       stb_q, stb_d;
	logic [7:0] data_q, data_d;
	logic       rise;
	logic       act;

	// Two-stage synchronisers, plus a delayed copy for edge finding
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_sync_q   <= 2'b11;
			sclk_sync_q <= 2'b00;
			sdi_sync_q  <= 2'b00;
			sclk_prev_q <= 1'b0;
		end else begin
			cs_sync_q   <= {cs_sync_q[0], cs_n};
			sclk_sync_q <= {sclk_sync_q[0], sclk};
			sdi_sync_q  <= {sdi_sync_q[0], sdi};
			sclk_prev_q <= sclk_sync_q[1];
		end
	end

	assign rise = sclk_sync_q[1] & ~sclk_prev_q;
	assign act  = ~cs_sync_q[1];

	// Shift in MSB first on each rising edge inside a frame
	always_comb begin
		bit_cnt_d = bit_cnt_q;
		shift_d   = shift_q;
		stb_d     = 1'b0;
		data_d    = data_q;
		if (!act) begin
			bit_cnt_d = 3'd0;
		end else if (rise) begin
			shift_d   = {shift_q[6:0], sdi_sync_q[1]};
			bit_cnt_d = bit_cnt_q + 3'd1;
			if (bit_cnt_q == 3'd7) begin
				stb_d  = 1'b1;
				data_d = {shift_q[6:0], sdi_sync_q[1]};
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_q <= 3'd0;
			shift_q   <= 8'h00;
			stb_q     <= 1'b0;
			data_q    <= 8'h00;
		end else begin
			bit_cnt_q <= bit_cnt_d;
			shift_q   <= shift_d;
			stb_q     <= stb_d;
			data_q    <= data_d;
		end
	end

	assign ser.sclk_rise = rise & act;
	assign ser.frame_act = act;
	assign ser.byte_stb  = stb_q;
	assign ser.byte_data = data_q;
endmodule
`default_nettype wire

// *** rtl/arc_top.sv ***
// Setup command decode, pair registers and reference timing
//
// Behaviour
// - Clock mode 11 times reference delays by host serial clock, at most 3.6 MHz.
// - Internal reference modes switch the reference off once a scan finishes.
// - Analog conversion in reference modes 00 and 10 with internal reference off waits 218 clock cycles first.
// - Temperature conversion powers the reference and waits 244 cycles to settle.
// - Temperature result appears 188 cycles after settling; host keeps clocking.
// - Reference modes 01 and 11 leave reference unused for analog conversions and add no wake delay.
// - Reference mode 10 is the reset default and shuts reference after scans.
// - Pair select 00 or 01 expects no data byte, pair registers unchanged.
// - With pair select 00 or 01 the next byte is a new command.
// - Pair select 10 loads the following byte into the unipolar pair register.
// - Pair select 11 loads the following byte into the bipolar pair register.
// - Unipolar bits 7,6,5,4 mark pairs 0/1, 2/3, 4/5, 6/7.
// - Both pair registers reset to zero, all inputs single-ended.
`timescale 1ns/1ps
`default_nettype none
module arc_top
	import arc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       cs_n,
	input  wire logic       sclk,
	input  wire logic       sdi,
	input  wire logic       conv_req,
	input  wire logic       conv_temp,
	input  wire logic       scan_done,
	output logic            clock_mode_sel_hi,
	output logic            clock_mode_sel_lo,
	output logic            ref_mode_sel_hi,
	output logic            ref_mode_sel_lo,
	output logic            pair_reg_sel_hi,
	output logic            pair_reg_sel_lo,
	output logic [7:0]      unipolar_pair_config,
	output logic [7:0]      bipolar_pair_config,
	output logic            pair01_unipolar_diff,
	output logic            pair23_unipolar_diff,
	output logic            pair45_unipolar_diff,
	output logic            pair67_unipolar_diff,
	output logic            int_ref_on,
	output logic            conv_go,
	output logic            temp_out_ready
);
	arc_ser_if ser ();

	arc_ser_rx u_rx (
		.clk   (clk),
		.rst_n (rst_n),
		.cs_n  (cs_n),
		.sclk  (sclk),
		.sdi   (sdi),
		.ser   (ser)
	);

	arc_cmd_st_t          cst_q, cst_d;
	logic [1:0]           clk_mode_q, clk_mode_d;
	logic [1:0]           ref_mode_q, ref_mode_d;
	logic [1:0]           pair_sel_q, pair_sel_d;
	logic [3:0]           uni_q, uni_d;
	logic [3:0]           bip_q, bip_d;
	logic [7:0]           b;
	logic                 is_setup;

	assign b        = ser.byte_data;
	assign is_setup = (b[ARC_ID_HI_BIT:ARC_ID_LO_BIT] == ARC_SETUP_ID);

	// Command byte decode and pair register loading
	always_comb begin
		cst_d      = cst_q;
		clk_mode_d = clk_mode_q;
		ref_mode_d = ref_mode_q;
		pair_sel_d = pair_sel_q;
		uni_d      = uni_q;
		bip_d      = bip_q;
		if (!ser.frame_act) begin
			cst_d = ARC_ST_CMD;
		end else if (ser.byte_stb) begin
			case (cst_q)
				ARC_ST_CMD: begin
					if (is_setup) begin
						clk_mode_d = b[ARC_CLK_HI_BIT:ARC_CLK_LO_BIT];
						ref_mode_d = b[ARC_REF_HI_BIT:ARC_REF_LO_BIT];
						pair_sel_d = b[ARC_PAIR_HI_BIT:ARC_PAIR_LO_BIT];
						// Data byte only for select 1x, else next is a command
						cst_d = b[ARC_PAIR_HI_BIT] ? ARC_ST_DATA : ARC_ST_CMD;
					end
				end
				ARC_ST_DATA: begin
					// Only the upper nibble is kept
					if (pair_sel_q[0]) begin
						bip_d = b[ARC_PAIR_MSB:ARC_PAIR_LSB];
					end else begin
						uni_d = b[ARC_PAIR_MSB:ARC_PAIR_LSB];
					end
					cst_d = ARC_ST_CMD;
				end
				default: cst_d = ARC_ST_CMD;
			endcase
		end
	end

	// Command state and configuration registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cst_q      <= ARC_ST_CMD;
			clk_mode_q <= ARC_CLK_MODE_RST;
			ref_mode_q <= ARC_REF_MODE_RST;
			pair_sel_q <= ARC_PAIR_SEL_RST;
			uni_q      <= ARC_PAIR_RST;
			bip_q      <= ARC_PAIR_RST;
		end else begin
			cst_q      <= cst_d;
			clk_mode_q <= clk_mode_d;
			ref_mode_q <= ref_mode_d;
			pair_sel_q <= pair_sel_d;
			uni_q      <= uni_d;
			bip_q      <= bip_d;
		end
	end

	arc_ref_st_t          rst_q, rst_d;
	logic [ARC_CNT_W-1:0] cnt_q, cnt_d;
	logic                 ref_on_q, ref_on_d;
	logic                 go_q, go_d;
	logic                 tready_q, tready_d;
	logic                 tick;
	logic                 int_mode;

	// External clock mode counts serial clock edges, else system clocks
	assign tick     = (clk_mode_q == ARC_CLK_EXT) ? ser.sclk_rise : 1'b1;
	// Codes 00 and 10 use the internal reference for conversions
	assign int_mode = ~ref_mode_q[0];

	// Reference power, wake and temperature timing
	always_comb begin
		rst_d    = rst_q;
		cnt_d    = cnt_q;
		ref_on_d = ref_on_q;
		go_d     = 1'b0;
		tready_d = tready_q;
		case (rst_q)
			ARC_R_IDLE: begin
				if (conv_req) begin
					tready_d = 1'b0;
					cnt_d    = '0;
					if (conv_temp) begin
						ref_on_d = 1'b1;
						rst_d    = ARC_R_SETTLE;
					end else if (int_mode && !ref_on_q) begin
						ref_on_d = 1'b1;
						rst_d    = ARC_R_WAKE;
					end else begin
						go_d = 1'b1;
						if (!int_mode) begin
							ref_on_d = 1'b0;
						end
					end
				end else if (scan_done && int_mode) begin
					ref_on_d = 1'b0;
				end
			end
			ARC_R_WAKE: begin
				if (tick) begin
					if (cnt_q == ARC_WAKE_CYC - 8'd1) begin
						go_d  = 1'b1;
						cnt_d = '0;
						rst_d = ARC_R_IDLE;
					end else begin
						cnt_d = cnt_q + 8'd1;
					end
				end
			end
			ARC_R_SETTLE: begin
				if (tick) begin
					if (cnt_q == ARC_SETTLE_CYC - 8'd1) begin
						cnt_d = '0;
						rst_d = ARC_R_TOUT;
					end else begin
						cnt_d = cnt_q + 8'd1;
					end
				end
			end
			ARC_R_TOUT: begin
				if (tick) begin
					if (cnt_q == ARC_TEMP_LAT_CYC - 8'd1) begin
						tready_d = 1'b1;
						cnt_d    = '0;
						rst_d    = ARC_R_IDLE;
						// External modes need the reference only for temperature
						if (!int_mode) begin
							ref_on_d = 1'b0;
						end
					end else begin
						cnt_d = cnt_q + 8'd1;
					end
				end
			end
			default: rst_d = ARC_R_IDLE;
		endcase
	end

	// Reference timing registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_q    <= ARC_R_IDLE;
			cnt_q    <= '0;
			ref_on_q <= 1'b0;
			go_q     <= 1'b0;
			tready_q <= 1'b0;
		end else begin
			rst_q    <= rst_d;
			cnt_q    <= cnt_d;
			ref_on_q <= ref_on_d;
			go_q     <= go_d;
			tready_q <= tready_d;
		end
	end

	// Outputs
	assign clock_mode_sel_hi    = clk_mode_q[1];
	assign clock_mode_sel_lo    = clk_mode_q[0];
	assign ref_mode_sel_hi      = ref_mode_q[1];
	assign ref_mode_sel_lo      = ref_mode_q[0];
	assign pair_reg_sel_hi      = pair_sel_q[1];
	assign pair_reg_sel_lo      = pair_sel_q[0];
	assign unipolar_pair_config = {uni_q, 4'h0};
	assign bipolar_pair_config  = {bip_q, 4'h0};
	assign pair01_unipolar_diff = uni_q[3];
	assign pair23_unipolar_diff = uni_q[2];
	assign pair45_unipolar_diff = uni_q[1];
	assign pair67_unipolar_diff = uni_q[0];
	assign int_ref_on           = ref_on_q;
	assign conv_go              = go_q;
	assign temp_out_ready       = tready_q;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	ext_ref_nodelay_a: assert property (
		(rst_q == ARC_R_IDLE && conv_req && !conv_temp && ref_mode_q[0]) |=> conv_go && !int_ref_on
	) else $error("external reference conversion delayed");
	scan_ref_off_a: assert property (
		(rst_q == ARC_R_IDLE && !conv_req && scan_done && !ref_mode_q[0]) |=> !int_ref_on
	) else $error("reference not off after scan");
	wake_count_a: assert property (
		(conv_go && $past(rst_q) == ARC_R_WAKE) |-> $past(cnt_q) == 8'd217
	) else $error("wake delay length wrong");
	wake_start_a: assert property (
		(rst_q == ARC_R_IDLE && conv_req && !conv_temp && !ref_mode_q[0] && !int_ref_on)
			|=> !conv_go && rst_q == ARC_R_WAKE && int_ref_on
	) else $error("wake delay skipped");
	temp_ref_on_a: assert property (
		(rst_q == ARC_R_SETTLE || rst_q == ARC_R_TOUT) |-> int_ref_on
	) else $error("reference off during temperature");
	settle_len_a: assert property (
		(rst_q == ARC_R_SETTLE && tick && cnt_q == 8'd243) |=> rst_q == ARC_R_TOUT && cnt_q == 8'd0
	) else $error("settle delay length wrong");
	temp_latency_a: assert property (
		$rose(temp_out_ready) |-> $past(rst_q) == ARC_R_TOUT && $past(cnt_q) == 8'd187
	) else $error("temperature latency wrong");
	pair_hold_a: assert property (
		(ser.byte_stb && cst_q == ARC_ST_CMD && is_setup && !b[1])
			|=> $stable(unipolar_pair_config) && $stable(bipolar_pair_config)
	) else $error("pair register changed");
	next_cmd_a: assert property (
		(ser.frame_act && ser.byte_stb && cst_q == ARC_ST_CMD && is_setup && !b[1])
			|=> cst_q == ARC_ST_CMD
	) else $error("data byte expected wrongly");
	uni_load_a: assert property (
		(ser.frame_act && ser.byte_stb && cst_q == ARC_ST_DATA && pair_sel_q == 2'b10)
			|=> unipolar_pair_config == {$past(b[7:4]), 4'h0} && $stable(bipolar_pair_config)
	) else $error("unipolar register not loaded");
	bip_load_a: assert property (
		(ser.frame_act && ser.byte_stb && cst_q == ARC_ST_DATA && pair_sel_q == 2'b11)
			|=> bipolar_pair_config == {$past(b[7:4]), 4'h0} && $stable(unipolar_pair_config)
	) else $error("bipolar register not loaded");
	pair_map_a: assert property (
		{pair01_unipolar_diff, pair23_unipolar_diff, pair45_unipolar_diff,
			pair67_unipolar_diff} == unipolar_pair_config[7:4]
	) else $error("pair bit mapping wrong");
	low_nibble_a: assert property (
		unipolar_pair_config[3:0] == 4'h0
	) else $error("low nibble not ignored");

	uni_write_c: cover property (ser.byte_stb && cst_q == ARC_ST_DATA && !pair_sel_q[0]);
	bip_write_c: cover property (ser.byte_stb && cst_q == ARC_ST_DATA && pair_sel_q[0]);
	wake_done_c: cover property (conv_go && $past(rst_q) == ARC_R_WAKE);
	temp_done_c: cover property ($rose(temp_out_ready));
endmodule
`default_nettype wire

// *** tb/arc_host_model.sv ***
// Serial host model driving chip select, serial clock and data
`timescale 1ns/1ps
`default_nettype none
module arc_host_model (
	input  wire logic clk,
	output logic      cs_n,
	output logic      sclk,
	output logic      sdi
);
	// Idle bus, clock stands still outside frames
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi  = 1'b0;
	end

	// Half a serial clock period, 160 ns
	task automatic half();
		repeat (4) @(posedge clk);
	endtask

	// One frame of n clocks, MSB first, zeros past bit 16
	task automatic frame(input logic [15:0] b, input int n);
		@(posedge clk);
		cs_n <= 1'b0;
		half();
		for (int i = 0; i < n; i++) begin
			sdi <= (i < 16) ? b[15 - i] : 1'b0;
			half();
			sclk <= 1'b1; // Conversion clock in clock mode 11
			half();
			sclk <= 1'b0;
		end
		half();
		cs_n <= 1'b1; // Raised only after all 16 clocks of a load
		sdi  <= ~sdi; // Released line shows no stale value
		half();
	endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench of the setup decode and reference timing
`timescale 1ns/1ps
`default_nettype none
module testbench
	import arc_pkg::*;
();
	logic       clk;
	logic       rst_n;
	logic       conv_req;
	logic       conv_temp;
	logic       scan_done;
	wire logic  cs_n;
	wire logic  sclk;
	wire logic  sdi;
	logic       ckh, ckl, rfh, rfl, psh, psl;
	logic       p01, p23, p45, p67;
	logic       ref_on, go, tready;
	logic [7:0] uni;
	logic [7:0] bip;
	int         miscompares;
	int         comparisons;
	int         n;

	arc_host_model host_u (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));

	arc_top dut_u (
		.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
		.conv_req(conv_req), .conv_temp(conv_temp), .scan_done(scan_done),
		.clock_mode_sel_hi(ckh), .clock_mode_sel_lo(ckl),
		.ref_mode_sel_hi(rfh), .ref_mode_sel_lo(rfl),
		.pair_reg_sel_hi(psh), .pair_reg_sel_lo(psl),
		.unipolar_pair_config(uni), .bipolar_pair_config(bip),
		.pair01_unipolar_diff(p01), .pair23_unipolar_diff(p23),
		.pair45_unipolar_diff(p45), .pair67_unipolar_diff(p67),
		.int_ref_on(ref_on), .conv_go(go), .temp_out_ready(tready)
	);

	// 25 MHz clock
	always #20 clk = ~clk;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic modes(input logic [5:0] exp, input string what);
		chk({2'b00, ckh, ckl, rfh, rfl, psh, psl}, {2'b00, exp}, what);
	endtask

	task automatic send(input logic [15:0] b, input int nb);
		host_u.frame(b, nb);
		repeat (6) @(posedge clk);
		#1;
	endtask

	task automatic req(input logic t);
		@(posedge clk);
		conv_req  <= 1'b1;
		conv_temp <= t;
		@(posedge clk);
		conv_req  <= 1'b0;
	endtask

	// Edges from request to conversion start, zero when it starts at once
	task automatic wait_go();
		n = 0;
		#1;
		while (go !== 1'b1 && n < 1000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (go !== 1'b1) begin
			miscompares++;
			$display("BAD %0t conversion start never seen", $time);
		end
	endtask

	task automatic t_reset();
		modes(6'b10_10_00, "reset modes");
		chk(uni, 8'h00, "reset uni");
		chk(bip, 8'h00, "reset bip");
		chk({5'h0, ref_on, go, tready}, 8'h00, "reset status");
		$display("test reset done");
	endtask

	task automatic t_pairs();
		send(16'h6aa5, 16);
		chk(uni, 8'ha0, "uni load");
		chk({4'h0, p01, p23, p45, p67}, 8'h0a, "pair bits");
		chk(bip, 8'h00, "bip kept");
		send(16'h6b5f, 16);
		chk(bip, 8'h50, "bip load");
		chk(uni, 8'ha0, "uni kept");
		$display("test pairs done");
	endtask

	task automatic t_nodata();
		for (int s = 0; s < 2; s++) begin
			send({6'b011010, s[1:0], 8'h7c}, 16);
			chk(uni, 8'ha0, "uni untouched");
			chk(bip, 8'h50, "bip untouched");
			modes(6'b11_11_00, "second byte is command");
			send(16'h6800, 8);
			modes(6'b10_10_00, "restore");
		end
		$display("test nodata done");
	endtask

	task automatic t_wake();
		req(1'b0);
		wait_go();
		chk(n[7:0], ARC_WAKE_CYC, "wake delay");
		chk({7'h0, ref_on}, 8'h01, "ref on");
		req(1'b0);
		wait_go();
		chk(n[7:0], 8'd0, "no wake when on");
		@(posedge clk);
		scan_done <= 1'b1;
		@(posedge clk);
		scan_done <= 1'b0;
		@(posedge clk);
		#1;
		chk({7'h0, ref_on}, 8'h00, "ref off after scan");
		$display("test wake done");
	endtask

	task automatic t_extref();
		for (int m = 1; m < 4; m += 2) begin
			send({4'b0110, m[1:0], 2'b00, 8'h00}, 8);
			req(1'b0);
			wait_go();
			chk(n[7:0], 8'd0, "ext ref no delay");
			chk({7'h0, ref_on}, 8'h00, "ext ref unused");
		end
		$display("test extref done");
	endtask

	task automatic t_temp();
		send(16'h7000, 8);
		modes(6'b11_00_00, "ext clock mode");
		req(1'b1);
		repeat (100) @(posedge clk);
		#1;
		chk({7'h0, ref_on}, 8'h01, "temp powers ref");
		chk({7'h0, tready}, 8'h00, "no ticks no progress");
		host_u.frame(16'h0000, 431);
		repeat (6) @(posedge clk);
		#1;
		chk({7'h0, tready}, 8'h00, "temp not early");
		host_u.frame(16'h0000, 1);
		#1;
		chk({7'h0, tready}, 8'h01, "temp after 432");
		req(1'b0);
		wait_go();
		chk({7'h0, tready}, 8'h00, "temp ready cleared");
		$display("test temp done");
	endtask

	task automatic conclude();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		clk         = 1'b0;
		rst_n       = 1'b0;
		conv_req    = 1'b0;
		conv_temp   = 1'b0;
		scan_done   = 1'b0;
		miscompares = 0;
		comparisons = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		t_reset();
		t_pairs();
		t_nodata();
		t_wake();
		t_extref();
		t_temp();
		conclude();
	end

	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		$display("BAD %0t watchdog expired", $time);
		conclude();
	end
endmodule
`default_nettype wire
